// ===== logic/ram_sweep_address_sequencer.sv
// RAM sweep address sequencer with APB register slave
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module ram_sweep_address_sequencer
  import sweep_pkg::*;
#(
  parameter int AW = ADDR_W
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from the host controller
  input wire logic profile_select_lo,
  input wire logic profile_select_hi,
  input wire logic update_strobe,
  // ram side
  output logic [AW-1:0] ram_addr,
  output logic ram_dest,
  output logic sweep_done
);
  if (AW != ADDR_W) begin : g_chk
    $error("AW must match the segment word address field");
  end

  function automatic logic [AW-1:0] f_beg(input logic [31:0] w);
    return w[SCW_BEG_LO +: AW];
  endfunction
  function automatic logic [AW-1:0] f_fin(input logic [31:0] w);
    return w[SCW_FIN_LO +: AW];
  endfunction
  function automatic logic [RATE_W-1:0] f_rate(input logic [31:0] w);
    return w[SCW_RATE_LO +: RATE_W];
  endfunction
  function automatic logic [MODE_W-1:0] f_mode(input logic [31:0] w);
    return w[SCW_MODE_LO +: MODE_W];
  endfunction
  function automatic logic [31:0] f_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction

  // buffered and active registers
  logic [31:0] ctrl_buf_q, ctrl_act_q;
  logic [31:0] scw_buf_q [4];
  logic [31:0] scw_act_q [4];
  // pin synchronisers and filtered levels
  logic [2:0] sync_lo_q, sync_hi_q, sync_up_q;
  logic lo_q, hi_q, up_q;
  // sequencer state
  logic [AW-1:0] addr_q;
  logic [RATE_W-1:0] tmr_q;
  logic [1:0] prof_q;
  logic going_up_q, done_q, start_q, dest_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;

  // apb decode
  wire logic access = psel & penable;
  wire logic is_ctrl = (paddr == OFS_CTRL);
  wire logic is_scw = (paddr >= OFS_SCW0) && (paddr <= OFS_SCW3) && (paddr[1:0] == 2'h0);
  wire logic is_stat = (paddr == OFS_STAT);
  wire logic bad_addr = ~(is_ctrl | is_scw | is_stat);
  wire logic [1:0] widx = 2'(paddr[4:2] - 3'h1);
  wire logic wr_en = access & pready_q & pwrite & ~pslverr_q;
  wire logic [31:0] stat_word = {10'h000, going_up_q, done_q, 2'h0, prof_q,
                                  6'h00, addr_q};
  wire logic [31:0] rd_word = is_ctrl ? ctrl_buf_q :
                              is_scw ? scw_buf_q[widx] :
                              is_stat ? stat_word : 32'h0000_0000;

  // filtered pin levels and their changes
  wire logic lo_d = (sync_lo_q[1] == sync_lo_q[2]) ? sync_lo_q[2] : lo_q;
  wire logic hi_d = (sync_hi_q[1] == sync_hi_q[2]) ? sync_hi_q[2] : hi_q;
  wire logic up_d = (sync_up_q[1] == sync_up_q[2]) ? sync_up_q[2] : up_q;
  wire logic upd_rise = up_d & ~up_q;
  wire logic lo_chg = lo_d ^ lo_q;
  wire logic hi_chg = hi_d ^ hi_q;

  // mode selection
  wire logic ram_en = ctrl_act_q[CTRL_RAM_EN];
  wire logic [2:0] ipc = ctrl_act_q[CTRL_IPC_LO +: 3];
  wire logic ipc_on = ram_en && (ipc != IPC_OFF) && (ipc != IPC_BAD);
  wire logic ipc_single = ~ipc[2];
  wire logic [1:0] ipc_last = ipc_single ? ipc[1:0] : 2'(ipc[1:0] + 2'h1);
  // new pin levels pick the word at once, so a pin restart loads the new profile
  wire logic [1:0] pin_prof = {hi_d, lo_d};
  wire logic [MODE_W-1:0] pin_mode = f_mode(scw_act_q[pin_prof]);
  wire logic bidir = ram_en & ~ipc_on & (pin_mode == MODE_BIDIR);
  wire logic cbidir = ram_en & ~ipc_on & (pin_mode == MODE_CBIDIR);
  wire logic recirc = ram_en & ~ipc_on & (pin_mode == MODE_RECIRC);
  // directed ramp reads begin, final and rate from word zero only; its mode comes from the pin-selected word
  wire logic [1:0] ipc_prof = start_q ? 2'h0 : prof_q;
  wire logic [1:0] sel_prof = ipc_on ? ipc_prof : (bidir ? 2'h0 : pin_prof);
  wire logic [31:0] sel_w = scw_act_q[sel_prof];
  wire logic [AW-1:0] beg_a = f_beg(sel_w);
  wire logic [AW-1:0] fin_a = f_fin(sel_w);
  wire logic [RATE_W-1:0] rate = f_rate(sel_w);
  wire logic at_fin = (addr_q == fin_a);
  wire logic at_beg = (addr_q == beg_a);
  wire logic expire = ram_en & ~start_q & (tmr_q <= RATE_W'(1));
  // pin events: internal profiles disconnect both pins
  wire logic pin_restart = ~ipc_on & ram_en & (cbidir | recirc) & (lo_chg | hi_chg);
  wire logic dir_flip = bidir & lo_chg;
  wire logic [1:0] next_prof = (prof_q == ipc_last) ? 2'h0 : 2'(prof_q + 2'h1);
  wire logic [AW-1:0] next_beg = f_beg(scw_act_q[next_prof]);

  // address and timer next values
  logic [AW-1:0] addr_d;
  logic [RATE_W-1:0] tmr_d;
  logic [1:0] prof_d;
  logic up_dir_d, done_d;
  always_comb
  begin
    addr_d = addr_q;
    tmr_d = tmr_q;
    prof_d = prof_q;
    up_dir_d = going_up_q;
    done_d = done_q;
    if (start_q)
    begin
      addr_d = beg_a;
      tmr_d = rate;
      up_dir_d = 1'b1;
      done_d = 1'b0;
    end else if (pin_restart)
    begin
      addr_d = beg_a;
      tmr_d = rate;
      up_dir_d = 1'b1;
    end else if (dir_flip)
    begin
      tmr_d = rate;
      if (lo_d && !at_fin)
        addr_d = AW'(addr_q + 1'b1);
      else if (!lo_d && !at_beg)
        addr_d = AW'(addr_q - 1'b1);
    end else if (expire)
    begin
      tmr_d = rate;
      if (ipc_on)
      begin
        if (!done_q && at_fin)
        begin
          if (prof_q == ipc_last && ipc_single)
            done_d = 1'b1;
          else
          begin
            prof_d = next_prof;
            addr_d = next_beg;
          end
        end else if (!done_q)
          addr_d = AW'(addr_q + 1'b1);
      end else if (bidir)
      begin
        if (lo_q && !at_fin)
          addr_d = AW'(addr_q + 1'b1);
        else if (!lo_q && !at_beg)
          addr_d = AW'(addr_q - 1'b1);
      end else if (cbidir)
      begin
        if (going_up_q ? at_fin : at_beg)
          up_dir_d = ~going_up_q;
        if ((going_up_q && !at_fin) || (!going_up_q && at_beg))
          addr_d = AW'(addr_q + 1'b1);
        else if (!at_beg || !at_fin)
          addr_d = AW'(addr_q - 1'b1);
      end else if (recirc)
        addr_d = at_fin ? beg_a : AW'(addr_q + 1'b1);
    end else if (ram_en)
      tmr_d = RATE_W'(tmr_q - 1'b1);
  end

  // apb registers and update transfer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ctrl_buf_q <= REG_RST;
      ctrl_act_q <= REG_RST;
      for (int i = 0; i < 4; i++)
      begin
        scw_buf_q[i] <= REG_RST;
        scw_act_q[i] <= REG_RST;
      end
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= REG_RST;
    end else
    begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & bad_addr;
      prdata_q <= (access & ~pready_q & ~pwrite) ? rd_word : REG_RST;
      if (wr_en && is_ctrl)
        ctrl_buf_q <= f_merge(ctrl_buf_q, pwdata, pstrb);
      if (wr_en && is_scw)
        scw_buf_q[widx] <= f_merge(scw_buf_q[widx], pwdata, pstrb);
      if (upd_rise)
      begin
        ctrl_act_q <= ctrl_buf_q;
        for (int i = 0; i < 4; i++)
          scw_act_q[i] <= scw_buf_q[i];
      end
    end
  end

  // pin synchronisers and sequencer state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sync_lo_q <= 3'h0;
      sync_hi_q <= 3'h0;
      sync_up_q <= 3'h0;
      lo_q <= 1'b0;
      hi_q <= 1'b0;
      up_q <= 1'b0;
      addr_q <= '0;
      tmr_q <= '0;
      prof_q <= 2'h0;
      going_up_q <= 1'b1;
      done_q <= 1'b0;
      start_q <= 1'b0;
      dest_q <= 1'b0;
    end else
    begin
      sync_lo_q <= {sync_lo_q[1:0], profile_select_lo};
      sync_hi_q <= {sync_hi_q[1:0], profile_select_hi};
      sync_up_q <= {sync_up_q[1:0], update_strobe};
      lo_q <= lo_d;
      hi_q <= hi_d;
      up_q <= up_d;
      start_q <= upd_rise;
      addr_q <= addr_d;
      tmr_q <= tmr_d;
      prof_q <= start_q ? 2'h0 : prof_d;
      going_up_q <= up_dir_d;
      done_q <= done_d;
      dest_q <= ctrl_act_q[CTRL_DEST];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ram_addr = addr_q;
  assign ram_dest = dest_q;
  assign sweep_done = done_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic quiet = ~start_q & ~pin_restart & ~dir_flip;

  a_update_copy: assert property (upd_rise |=> ctrl_act_q == $past(ctrl_buf_q))
    else $error("update did not copy control word");
  a_pin_no_update: assert property (!upd_rise && lo_chg |=> $stable(ctrl_act_q))
    else $error("select pin changed active control");
  a_start_load: assert property (start_q |=> addr_q == $past(beg_a) && tmr_q == $past(rate))
    else $error("start did not load begin and rate");
  a_bidir_step: assert property (quiet && expire && bidir && lo_q && !at_fin
    |=> addr_q == AW'($past(addr_q) + 1'b1))
    else $error("directed ramp did not step up");
  a_bidir_stall: assert property (quiet && expire && bidir && at_fin && lo_q
    |=> $stable(addr_q))
    else $error("directed ramp moved past final");
  a_flip_reload: assert property (dir_flip && !start_q |=> tmr_q == $past(rate))
    else $error("direction change did not reload timer");
  a_hi_ignored: assert property (bidir && hi_chg && !lo_chg && quiet && !expire
    |=> $stable(addr_q))
    else $error("high select moved directed ramp");
  a_recirc_wrap: assert property (quiet && expire && recirc && at_fin
    |=> addr_q == $past(beg_a))
    else $error("recirculation did not wrap");
  a_ipc_pins_off: assert property (ipc_on && (lo_chg || hi_chg) && quiet && !expire
    |=> $stable(addr_q))
    else $error("internal profiles reacted to pins");
  a_burst_halt: assert property (done_q && !start_q |=> $stable(addr_q) && done_q)
    else $error("halted burst moved");
  a_ipc_advance: assert property (quiet && expire && ipc_on && !done_q && at_fin
    && prof_q != ipc_last |=> prof_q == $past(next_prof))
    else $error("profile did not advance");
  a_dest_route: assert property (##1 ram_dest == $past(ctrl_act_q[CTRL_DEST]))
    else $error("destination not routed");

  c_bidir_stall: cover property (bidir && at_fin && expire);
  c_cbidir_turn: cover property (cbidir && expire && at_fin && going_up_q);
  c_burst_done: cover property (ipc_on && $rose(done_q));
  c_loop_wrap: cover property (ipc_on && !ipc_single && expire && at_fin && prof_q == ipc_last);
endmodule // ram_sweep_address_sequencer
`default_nettype wire

// ===== logic/sweep_pkg.sv
// constants for the RAM sweep address sequencer
`default_nettype none
package sweep_pkg;
  localparam int ADDR_W = 10;
  localparam int RATE_W = 8;
  localparam int MODE_W = 3;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SCW0 = 8'h04;
  localparam logic [7:0] OFS_SCW3 = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // first control register fields
  localparam int CTRL_RAM_EN = 31;
  localparam int CTRL_DEST = 30;
  localparam int CTRL_IPC_LO = 27;
  // segment control word fields
  localparam int SCW_BEG_LO = 0;
  localparam int SCW_FIN_LO = 10;
  localparam int SCW_RATE_LO = 20;
  localparam int SCW_MODE_LO = 28;
  // status fields
  localparam int STAT_PROF_LO = 16;
  localparam int STAT_DONE = 20;
  localparam int STAT_UP = 21;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [MODE_W-1:0] MODE_BIDIR = 3'h2;
  localparam logic [MODE_W-1:0] MODE_CBIDIR = 3'h3;
  localparam logic [MODE_W-1:0] MODE_RECIRC = 3'h4;
  localparam logic [2:0] IPC_OFF = 3'h0;
  localparam logic [2:0] IPC_BAD = 3'h7;
endpackage
`default_nettype wire

// ===== sim/sweep_host_pins.sv
// host controller model driving the profile pins and the update strobe
`timescale 1ns/100ps
`default_nettype none
module sweep_host_pins (
  // clock
  input wire logic clk_sys,
  // pins toward the sequencer
  output logic profile_select_lo,
  output logic profile_select_hi,
  output logic update_strobe
);
  initial
  begin
    profile_select_lo = 1'b0;
    profile_select_hi = 1'b0;
    update_strobe = 1'b0;
  end
  // levels held 4 edges so the synchronisers settle
  task automatic set_prof(input logic [1:0] p);
    @(posedge clk_sys);
    {profile_select_hi, profile_select_lo} <= p;
    repeat (4) @(posedge clk_sys);
  endtask
  // only a rising edge copies buffered words
  task automatic pulse_update();
    @(posedge clk_sys);
    update_strobe <= 1'b1;
    repeat (4) @(posedge clk_sys);
    update_strobe <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // sweep_host_pins
`default_nettype wire

// ===== sim/ram_sweep_address_sequencer_tb_top.sv
// self-checking bench for the RAM sweep address sequencer
`timescale 1ns/100ps
`default_nettype none
module ram_sweep_address_sequencer_tb_top;
  import sweep_pkg::*;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, ram_dest, sweep_done, er;
  logic profile_select_lo, profile_select_hi, update_strobe;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rd, lfsr, v;
  logic [ADDR_W-1:0] ram_addr, last_a;
  logic [ADDR_W-1:0] got[$], expq[$];
  time tm[$];
  int err_count, comparisons, np;
  ram_sweep_address_sequencer ram_sweep_address_sequencer_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .profile_select_lo(profile_select_lo), .profile_select_hi(profile_select_hi),
    .update_strobe(update_strobe), .ram_addr(ram_addr), .ram_dest(ram_dest),
    .sweep_done(sweep_done));
  sweep_host_pins sweep_host_pins_i (.clk_sys(clk_sys), .profile_select_lo(profile_select_lo),
    .profile_select_hi(profile_select_hi), .update_strobe(update_strobe));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end
  // address trace with arrival times
  always @(posedge clk_sys)
    if (rst_b === 1'b1 && ram_addr !== last_a)
    begin
      got.push_back(ram_addr);
      tm.push_back($time);
      last_a = ram_addr;
    end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] w(input int b, input int f, input int r, input int m);
    return 32'((m << SCW_MODE_LO) | (r << SCW_RATE_LO) | (f << SCW_FIN_LO) | (b << SCW_BEG_LO));
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rd, e);
    chk({31'h0, er}, 32'h0000_0000);
  endtask
  task automatic go(input logic [31:0] c);
    wr(OFS_CTRL, c);
    got.delete();
    tm.delete();
    sweep_host_pins_i.pulse_update();
  endtask
  // reference trace for the up-down and recirculating ramps
  task automatic gen(input int m, input int b, input int f, input int n);
    int a;
    bit up;
    a = b;
    up = 1'b1;
    expq.delete();
    repeat (n)
    begin
      expq.push_back(ADDR_W'(a));
      if (m == 4)
        a = (a == f) ? b : a + 1;
      else
      begin
        up = (a == f) ? 1'b0 : (a == b) ? 1'b1 : up;
        a = up ? a + 1 : a - 1;
      end
    end
  endtask
  // drops stale entries, then compares the trace with the reference
  task automatic seq_chk(input int n);
    for (int i = 0; i < 3000; i++)
    begin
      while (got.size() > 0 && got[0] !== expq[0])
      begin
        got.delete(0);
        tm.delete(0);
      end
      if (got.size() >= n)
        break;
      @(posedge clk_sys);
    end
    chk(32'(got.size() >= n), 32'h0000_0001);
    for (int i = 0; i < n; i++)
      chk(32'(got[i]), 32'(expq[i]));
  endtask
  task automatic finish_test();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    {psel, penable, pwrite, rst_b} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    err_count = 0;
    comparisons = 0;
    lfsr = 32'h4593_9AC9;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdc(8'(4 * i), (i == 5) ? (32'h0000_0001 << STAT_UP) : REG_RST);
    apb(1'b0, 8'h18, 32'h0000_0000, 4'hF);
    chk({31'h0, er}, 32'h0000_0001);
    wr(OFS_STAT, 32'hFFFF_FFFF);
    rdc(OFS_STAT, 32'h0000_0001 << STAT_UP);
    lfsr = nxt(lfsr);
    v = lfsr & 32'h7FFF_FFFF;
    wr(8'h0C, v);
    rdc(8'h0C, v);
    lfsr = nxt(lfsr);
    apb(1'b1, OFS_SCW3, lfsr, 4'h2);
    rdc(OFS_SCW3, {16'h0000, lfsr[15:8], 8'h00});
    $display("test registers done");
    wr(OFS_SCW0, w(5, 8, 3, 4));
    go(32'hC000_0000);
    gen(4, 5, 8, 9);
    seq_chk(9);
    chk(32'(tm[3] - tm[2]), 32'h0000_0078);
    chk({31'h0, ram_dest}, 32'h0000_0001);
    wr(8'h08, w(20, 23, 1, 3));
    go(32'hC000_0000);
    got.delete();
    tm.delete();
    sweep_host_pins_i.set_prof(2'b01);
    gen(3, 20, 23, 10);
    seq_chk(10);
    $display("test continuous modes done");
    go(32'h0000_0000);
    wr(OFS_SCW0, w(40, 43, 2, 2));
    wr(8'h0C, w(100, 110, 1, 2));
    wr(OFS_SCW3, w(100, 110, 1, 2));
    sweep_host_pins_i.set_prof(2'b11);
    go(32'h8000_0000);
    expq = '{40, 41, 42, 43};
    seq_chk(4);
    repeat (30) @(posedge clk_sys);
    chk(32'(got.size()), 32'h0000_0004);
    wr(OFS_SCW0, w(42, 43, 2, 2));
    sweep_host_pins_i.set_prof(2'b10);
    expq = '{40, 41, 42, 43, 42, 41, 40};
    seq_chk(7);
    repeat (30) @(posedge clk_sys);
    chk(32'(got.size()), 32'h0000_0007);
    $display("test directed ramp done");
    for (int k = 0; k < 4; k++)
      wr(OFS_SCW0 + 8'(4 * k), w(50 + 10 * k, 51 + 10 * k, 1, 0));
    for (int c = 1; c < 7; c++)
    begin
      go(32'h0000_0000);
      np = (c < 4) ? c + 1 : c - 2;
      repeat ((c < 4) ? 2 : 1)
      begin
        go(32'h8000_0000 | (32'(c) << CTRL_IPC_LO));
        expq.delete();
        repeat ((c < 4) ? 1 : 2)
          for (int p = 0; p < np; p++)
          begin
            expq.push_back(ADDR_W'(50 + 10 * p));
            expq.push_back(ADDR_W'(51 + 10 * p));
          end
        seq_chk(expq.size());
        repeat (20) @(posedge clk_sys);
        if (c < 4)
          chk(32'(got.size()), 32'(expq.size()));
        chk({31'h0, sweep_done}, 32'(c < 4));
      end
    end
    $display("test internal profiles done");
    finish_test();
  end
endmodule // ram_sweep_address_sequencer_tb_top
`default_nettype wire
